/* File: logic/scrio_pkg.sv */
`default_nettype none
package scrio_pkg;
    // timing: system clock and output change pulse length
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned PULSE_MS = 10;
    localparam int unsigned PULSE_CYC = (CLK_HZ / 1000) * PULSE_MS;
    localparam int unsigned PULSE_W = $clog2(PULSE_CYC + 1);
    // ramp timebase tick; the pulse counter does not use it and counts system clock cycles
    localparam int unsigned TICK_US = 1;
    localparam int unsigned TICK_CYC = (CLK_HZ / 1_000_000) * TICK_US;

    // AXI4-Lite register map, byte addresses (layout chosen for this block)
    localparam logic [3:0] SCRIO_CTRL_ADDR = 4'h0;
    localparam logic [3:0] SCRIO_STAT_ADDR = 4'h4;
    localparam logic [3:0] SCRIO_CMD_ADDR = 4'h8;
    // control register fields
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned CTRL_LATCH_BIT = 1;
    localparam int unsigned CTRL_ARM_V_BIT = 2;
    localparam int unsigned CTRL_ARM_I_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    // command register fields (write one to act)
    localparam int unsigned CMD_PROT_CLR_BIT = 0;
    localparam int unsigned CMD_PANEL_CLR_BIT = 1;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SCRIO_CONSTANT_VOLTAGE,
        SCRIO_CONSTANT_CURRENT
    } scrio_reg_mode_t;

    typedef struct packed {
        logic output_enabled;
        logic fault;
        logic inhibit_fault;
        logic contact_open;
        logic mode_cc;
        logic pulse_active;
    } scrio_status_t;
endpackage : scrio_pkg
`default_nettype wire

/* File: logic/scrio_top.sv */
// Functional notes
// - The output is enabled while the remote on/off input is high and the software enable bit is set, and disabled while the input is low.
// - The regulation mode output is low in constant voltage and high in constant current.
// - The output enabled status is high exactly while the channel output is enabled.
// - An open inhibit contact disables the output and raises the inhibit fault.
// - In live mode the inhibit fault clears itself when the contact closes, allowing re-enable.
// - In latched mode the output stays off after closure and enabling is refused while latched.
// - A rising ramp trigger starts the armed voltage and current ramps of the channel.
// - Each change of the channel output drives the change pulse high for 10 ms, then low.
// - The fault flag output is high while the channel is in any fault state.
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`default_nettype none
module scrio_top
    import scrio_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = scrio_pkg::PULSE_CYC
) (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // connector inputs, isolated, asynchronous
    input wire logic REMOTE_OUTPUT_SWITCH_IN,
    input wire logic INHIBIT_CONTACT_IN,
    input wire logic RAMP_TRIGGER_IN,
    // from the regulation loop and other internal sources
    input wire logic REG_CC_IN,
    input wire logic OTHER_FAULT_IN,
    // connector outputs
    output logic REGULATION_MODE_OUT,
    output logic OUTPUT_ENABLED_STATUS_OUT,
    output logic FAULT_FLAG_OUT,
    output logic OUTPUT_CHANGE_PULSE_OUT,
    // to the regulation loop
    output logic OUTPUT_ENABLE,
    output logic RAMP_V_START,
    output logic RAMP_I_START,
    // AXI4-Lite slave
    input wire logic [3:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [3:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    import scrio_pkg::*;

    localparam int unsigned CW = $clog2(PULSE_CYCLES + 1);

    // two-stage synchronisers; stage one is read only by stage two
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic trig_d_r;
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            sync1_r <= 3'h2; // contact reads closed, so no false inhibit fault at release
            sync2_r <= 3'h2;
            trig_d_r <= 1'b0;
        end else begin
            sync1_r <= {RAMP_TRIGGER_IN, INHIBIT_CONTACT_IN, REMOTE_OUTPUT_SWITCH_IN};
            sync2_r <= sync1_r;
            trig_d_r <= sync2_r[2];
        end
    end
    logic sw_on;
    logic contact_closed;
    logic trig_rise;
    assign sw_on = sync2_r[0];
    // closed contact reads high on the synchronised input
    assign contact_closed = sync2_r[1];
    assign trig_rise = sync2_r[2] & ~trig_d_r;

    // software state
    logic [3:0] ctrl_r;
    logic prot_clr;
    logic panel_clr;
    logic latch_mode;
    assign latch_mode = ctrl_r[CTRL_LATCH_BIT];

    // inhibit fault: set wins over a clear in the same cycle
    logic inh_fault_r;
    logic inh_fault_nxt;
    always_comb begin
        inh_fault_nxt = inh_fault_r;
        if (!contact_closed) begin
            inh_fault_nxt = 1'b1;
        end else if (!latch_mode) begin
            inh_fault_nxt = 1'b0;
        end else if (prot_clr || panel_clr) begin
            inh_fault_nxt = 1'b0;
        end
    end
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            inh_fault_r <= 1'b0;
        end else begin
            inh_fault_r <= inh_fault_nxt;
        end
    end

    // output enable: needs remote switch high, software enable, no inhibit fault
    logic out_en_nxt;
    assign out_en_nxt = sw_on && ctrl_r[CTRL_EN_BIT] && contact_closed && !inh_fault_r;
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            OUTPUT_ENABLE <= 1'b0;
            OUTPUT_ENABLED_STATUS_OUT <= 1'b0;
        end else begin
            OUTPUT_ENABLE <= out_en_nxt;
            OUTPUT_ENABLED_STATUS_OUT <= out_en_nxt;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            REGULATION_MODE_OUT <= 1'b0;
            FAULT_FLAG_OUT <= 1'b0;
        end else begin
            REGULATION_MODE_OUT <= REG_CC_IN;
            FAULT_FLAG_OUT <= inh_fault_nxt | OTHER_FAULT_IN;
        end
    end

    // ramp starts only for armed functions
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            RAMP_V_START <= 1'b0;
            RAMP_I_START <= 1'b0;
        end else begin
            RAMP_V_START <= trig_rise & ctrl_r[CTRL_ARM_V_BIT];
            RAMP_I_START <= trig_rise & ctrl_r[CTRL_ARM_I_BIT];
        end
    end

    // change pulse: counter reloads on every change, so a late change restarts it
    logic [CW-1:0] pulse_cnt_r;
    logic out_change;
    assign out_change = out_en_nxt != OUTPUT_ENABLE;
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            pulse_cnt_r <= '0;
            OUTPUT_CHANGE_PULSE_OUT <= 1'b0;
        end else if (out_change) begin
            pulse_cnt_r <= CW'(PULSE_CYCLES - 1);
            OUTPUT_CHANGE_PULSE_OUT <= 1'b1;
        end else if (pulse_cnt_r != '0) begin
            pulse_cnt_r <= pulse_cnt_r - CW'(1);
        end else begin
            OUTPUT_CHANGE_PULSE_OUT <= 1'b0;
        end
    end

    // AXI4-Lite write: address and data taken in either order
    logic aw_got_r;
    logic w_got_r;
    logic [3:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic wr_go;
    assign wr_go = aw_got_r && w_got_r && !S_AXI_BVALID;
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_strb_r <= '0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
        end else begin
            S_AXI_AWREADY <= !aw_got_r && !S_AXI_AWREADY && S_AXI_AWVALID;
            S_AXI_WREADY <= !w_got_r && !S_AXI_WREADY && S_AXI_WVALID;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_got_r <= 1'b1;
                aw_addr_r <= S_AXI_AWADDR;
            end else if (wr_go) begin
                aw_got_r <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_got_r <= 1'b1;
                w_data_r <= S_AXI_WDATA;
                w_strb_r <= S_AXI_WSTRB;
            end else if (wr_go) begin
                w_got_r <= 1'b0;
            end
        end
    end

    logic wr_hit;
    assign wr_hit = aw_addr_r == SCRIO_CTRL_ADDR || aw_addr_r == SCRIO_CMD_ADDR || aw_addr_r == SCRIO_STAT_ADDR;
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= AXI_OKAY;
        end else if (wr_go) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_hit ? AXI_OKAY : AXI_SLVERR;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // commands are one-cycle pulses; status is read-only
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ctrl_r <= CTRL_RESET;
            prot_clr <= 1'b0;
            panel_clr <= 1'b0;
        end else begin
            prot_clr <= 1'b0;
            panel_clr <= 1'b0;
            if (wr_go && w_strb_r[0]) begin
                if (aw_addr_r == SCRIO_CTRL_ADDR) begin
                    ctrl_r <= w_data_r[3:0];
                end
                if (aw_addr_r == SCRIO_CMD_ADDR) begin
                    prot_clr <= w_data_r[CMD_PROT_CLR_BIT];
                    panel_clr <= w_data_r[CMD_PANEL_CLR_BIT];
                end
            end
        end
    end

    // AXI4-Lite read
    scrio_status_t stat;
    assign stat = '{output_enabled: OUTPUT_ENABLE, fault: FAULT_FLAG_OUT, inhibit_fault: inh_fault_r,
                    contact_open: !contact_closed, mode_cc: REGULATION_MODE_OUT,
                    pulse_active: OUTPUT_CHANGE_PULSE_OUT};
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= AXI_OKAY;
        end else begin
            S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= AXI_OKAY;
                case (S_AXI_ARADDR)
                    SCRIO_CTRL_ADDR: S_AXI_RDATA <= {28'h0, ctrl_r};
                    SCRIO_STAT_ADDR: S_AXI_RDATA <= {26'h0, stat};
                    SCRIO_CMD_ADDR: S_AXI_RDATA <= 32'h0;
                    default: begin
                        S_AXI_RDATA <= 32'h0;
                        S_AXI_RRESP <= AXI_SLVERR;
                    end
                endcase
            end else if (S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // assertions
    open_disables_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        !contact_closed |=> !OUTPUT_ENABLE && inh_fault_r) else $error("open contact left output on");
    switch_low_off_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        !sw_on |=> !OUTPUT_ENABLE) else $error("switch low but output on");
    status_tracks_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        OUTPUT_ENABLED_STATUS_OUT == OUTPUT_ENABLE) else $error("status differs from output");
    mode_follows_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        ##1 REGULATION_MODE_OUT == $past(REG_CC_IN)) else $error("mode output wrong");
    latch_holds_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        inh_fault_r && latch_mode && !prot_clr && !panel_clr |=> inh_fault_r) else $error("latched fault lost");
    live_clears_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        contact_closed && !latch_mode |=> !inh_fault_r) else $error("live fault not cleared");
    fault_flag_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        inh_fault_r |-> FAULT_FLAG_OUT) else $error("fault flag low in fault");
    pulse_start_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        out_change |=> OUTPUT_CHANGE_PULSE_OUT && pulse_cnt_r == CW'(PULSE_CYCLES - 1))
        else $error("pulse not restarted");
    ramp_edge_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        RAMP_V_START |-> $past(trig_rise)) else $error("ramp start without edge");
    ramp_i_edge_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        RAMP_I_START |-> $past(trig_rise)) else $error("current ramp start without edge");
    ramp_armed_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        trig_rise && ctrl_r[CTRL_ARM_V_BIT] |=> RAMP_V_START) else $error("armed ramp not started");
    inhibit_refuse_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        inh_fault_r |=> !OUTPUT_ENABLE) else $error("output on during inhibit fault");
    fault_other_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        OTHER_FAULT_IN |=> FAULT_FLAG_OUT) else $error("fault flag low on other fault");
    pulse_hold_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        OUTPUT_CHANGE_PULSE_OUT && pulse_cnt_r != '0 |=> OUTPUT_CHANGE_PULSE_OUT) else $error("pulse cut short");
    pulse_end_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        OUTPUT_CHANGE_PULSE_OUT && pulse_cnt_r == '0 && !out_change |=> !OUTPUT_CHANGE_PULSE_OUT)
        else $error("pulse too long");
endmodule : scrio_top
`default_nettype wire

/* File: test/scrio_remote_ctl.sv */
`default_nettype none
module scrio_remote_ctl (
    // clock
    input wire logic clk,
    // requests from the bench
    input wire logic want_on,
    input wire logic want_closed,
    input wire logic want_trig,
    // connector pins
    output logic switch_pin,
    output logic contact_pin,
    output logic trig_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // pins move just after a rising edge of the same clock on which the block samples them
    always @(posedge clk) begin
        switch_pin <= want_on;
        contact_pin <= want_closed;
        trig_pin <= want_trig;
    end
endmodule : scrio_remote_ctl
`default_nettype wire

/* File: test/test_scrio_top.sv */
`default_nettype none
module test_scrio_top;
    import scrio_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PC = 20;
    logic CLK_SYS = 1'h0, RST = 1'h1, REG_CC_IN = 1'h0, OTHER_FAULT_IN = 1'h0;
    logic REMOTE_OUTPUT_SWITCH_IN, INHIBIT_CONTACT_IN, RAMP_TRIGGER_IN;
    logic REGULATION_MODE_OUT, OUTPUT_ENABLED_STATUS_OUT, FAULT_FLAG_OUT, OUTPUT_CHANGE_PULSE_OUT;
    logic OUTPUT_ENABLE, RAMP_V_START, RAMP_I_START;
    logic [3:0] S_AXI_AWADDR = 4'h0, S_AXI_ARADDR = 4'h0, S_AXI_WSTRB = 4'h0;
    logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
    logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
    logic S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic want_on = 1'h0, want_closed = 1'h1, want_trig = 1'h0;
    int seed = 50, err_total = 0, checked = 0, pw = 0, last_pw = 0, vcnt = 0, icnt = 0;
    logic [1:0] bq[$];
    logic [33:0] rq[$];

    always #50 CLK_SYS = ~CLK_SYS;

    scrio_top #(.PULSE_CYCLES(PC)) u_scrio_top (.*);
    scrio_remote_ctl u_scrio_remote_ctl (.clk(CLK_SYS), .want_on(want_on), .want_closed(want_closed),
        .want_trig(want_trig), .switch_pin(REMOTE_OUTPUT_SWITCH_IN), .contact_pin(INHIBIT_CONTACT_IN),
        .trig_pin(RAMP_TRIGGER_IN));

    task automatic cmp_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: pin level %b, expected %b", $time, got, exp);
        end
    endtask : cmp_bit

    task automatic cmp_bus(input logic [33:0] got, input logic [33:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask : cmp_bus

    task automatic step(input int n);
        repeat (n) @(posedge CLK_SYS);
    endtask : step

    // called just after an edge; ends one edge after releasing bready
    task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        bq.push_back(er);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_WSTRB <= 4'hf;
        S_AXI_AWVALID <= 1'h1;
        S_AXI_WVALID <= 1'h1;
        S_AXI_BREADY <= 1'h1;
        do begin
            @(posedge CLK_SYS);
            if (S_AXI_AWREADY === 1'h1) S_AXI_AWVALID <= 1'h0;
            if (S_AXI_WREADY === 1'h1) S_AXI_WVALID <= 1'h0;
        end while (S_AXI_BVALID !== 1'h1);
        S_AXI_BREADY <= 1'h0;
        @(posedge CLK_SYS);
    endtask : axw

    task automatic axr(input logic [3:0] a, input logic [33:0] e);
        rq.push_back(e);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'h1;
        S_AXI_RREADY <= 1'h1;
        do begin
            @(posedge CLK_SYS);
            if (S_AXI_ARREADY === 1'h1) S_AXI_ARVALID <= 1'h0;
        end while (S_AXI_RVALID !== 1'h1);
        S_AXI_RREADY <= 1'h0;
        @(posedge CLK_SYS);
    endtask : axr

    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    // responses are matched in order against the notes left by the bus tasks
    always @(posedge CLK_SYS) begin
        if (S_AXI_BVALID && S_AXI_BREADY && bq.size() > 0) begin
            cmp_bus({32'h0, S_AXI_BRESP}, {32'h0, bq.pop_front()});
        end
        if (S_AXI_RVALID && S_AXI_RREADY && rq.size() > 0) cmp_bus({S_AXI_RRESP, S_AXI_RDATA}, rq.pop_front());
        if (OUTPUT_CHANGE_PULSE_OUT === 1'h1) begin
            pw++;
        end else if (pw != 0) begin
            last_pw = pw;
            pw = 0;
        end
        if (RAMP_V_START === 1'h1) vcnt++;
        if (RAMP_I_START === 1'h1) icnt++;
    end

    // whole run is well under 1000 cycles
    initial begin
        #2_000_000;
        err_total++;
        $display("Error at %0t: run timed out", $time);
        complete_run();
    end

    initial begin
        repeat (10) @(posedge CLK_SYS);
        RST <= 1'h0;
        axw(SCRIO_CTRL_ADDR, 32'h1, AXI_OKAY);
        want_on <= 1'h1;
        step(10);
        cmp_bit(OUTPUT_ENABLE, 1'h1);
        cmp_bit(OUTPUT_ENABLED_STATUS_OUT, 1'h1);
        step(PC);
        cmp_bus(34'(last_pw), 34'(PC));
        want_on <= 1'h0;
        step(10);
        cmp_bit(OUTPUT_ENABLE, 1'h0);
        cmp_bit(OUTPUT_ENABLED_STATUS_OUT, 1'h0);
        step(PC);
        // three changes five cycles apart keep stretching one pulse
        want_on <= 1'h1;
        step(5);
        want_on <= 1'h0;
        step(5);
        want_on <= 1'h1;
        step(3 * PC);
        cmp_bus(34'(last_pw), 34'(PC + 10));
        $display("test on_off done");
        for (int i = 0; i < 8; i++) begin
            REG_CC_IN <= 1'($random(seed));
            step(3);
            cmp_bit(REGULATION_MODE_OUT, REG_CC_IN);
        end
        OTHER_FAULT_IN <= 1'h1;
        step(3);
        cmp_bit(FAULT_FLAG_OUT, 1'h1);
        OTHER_FAULT_IN <= 1'h0;
        want_closed <= 1'h0;
        step(10);
        cmp_bit(OUTPUT_ENABLE, 1'h0);
        cmp_bit(FAULT_FLAG_OUT, 1'h1);
        want_closed <= 1'h1;
        step(10);
        cmp_bit(OUTPUT_ENABLE, 1'h1);
        cmp_bit(FAULT_FLAG_OUT, 1'h0);
        $display("test live inhibit done");
        for (int b = 0; b < 2; b++) begin
            axw(SCRIO_CTRL_ADDR, 32'h3, AXI_OKAY);
            want_closed <= 1'h0;
            step(10);
            want_closed <= 1'h1;
            step(10);
            axw(SCRIO_CTRL_ADDR, 32'h3, AXI_OKAY);
            step(5);
            cmp_bit(OUTPUT_ENABLE, 1'h0);
            cmp_bit(FAULT_FLAG_OUT, 1'h1);
            axw(SCRIO_CMD_ADDR, 32'(1 << b), AXI_OKAY);
            step(5);
            cmp_bit(OUTPUT_ENABLE, 1'h1);
            cmp_bit(FAULT_FLAG_OUT, 1'h0);
        end
        $display("test latched inhibit done");
        for (int k = 0; k < 4; k++) begin
            axw(SCRIO_CTRL_ADDR, 32'h1 | 32'(k << 2), AXI_OKAY);
            vcnt = 0;
            icnt = 0;
            want_trig <= 1'h1;
            step(10);
            want_trig <= 1'h0;
            step(5);
            cmp_bus(34'(vcnt), 34'(k & 1));
            cmp_bus(34'(icnt), 34'(k >> 1));
        end
        $display("test trigger done");
        // status writes are ignored, so the read below still shows the live state
        axw(SCRIO_STAT_ADDR, 32'h0, AXI_OKAY);
        axr(SCRIO_CTRL_ADDR, {AXI_OKAY, 32'hd});
        axr(SCRIO_CMD_ADDR, {AXI_OKAY, 32'h0});
        axr(SCRIO_STAT_ADDR, {AXI_OKAY, 26'h0, 4'h8, REG_CC_IN, 1'h0});
        axr(4'hc, {AXI_SLVERR, 32'h0});
        axw(4'hc, 32'h0, AXI_SLVERR);
        step(2);
        $display("test registers done");
        complete_run();
    end
endmodule : test_scrio_top
`default_nettype wire
